// *** design/sar_dev.sv ***
// Converter end of the serial readout link: start, convert, shift out,
// and on-demand self-calibration.
// Assumes link pins are asynchronous to clk and are synchronised here.
`timescale 1ns/100ps

// Summary of operation
// RL1: Start line rising edge starts sampling, conversion.
// RL2: Conversion runs to end regardless of start line.
// RL3: After conversion, start line low enables output.
// RL4: Shift result MSB first on serial clock falls.
// RL5: Host may capture on either serial clock edge.
// RL6: Release output after last bit or start high.
// RL7: Host holds serial input high during normal work.
// RL8: Exactly 1024 clocks in acquisition request calibration.
// RL9: Drive output low throughout calibration, then release.
// RL10: Host watches pulled-up output go high for completion.
// RL11: Calibration lasts about 500 ms.
// RL12: Two's complement result, saturating at both full scales.
// RL13: Host waits for calibration end before new work.
// RL14: MSB appears as soon as start line falls.
module sar_dev import sar_pkg::*; #(
  parameter int RES_BITS    = SAR_RES_BITS,
  parameter int CONV_CYCLES = SAR_CONV_CYCLES,
  parameter int CAL_CYCLES  = SAR_CAL_CYCLES
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Link to the host.
  sar_link_if.dev                    link,
  // Quantised input level, one bit wider than the result.
  input  wire logic signed [RES_BITS:0] sample_level,
  // Status and result towards local logic.
  output logic                       conv_busy,
  output logic                       cal_busy,
  output logic                       result_valid,
  output logic [RES_BITS-1:0]        result_code
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  // The timer is sized by the calibration count, so it must be longest.
  if (RES_BITS < 2 || CONV_CYCLES < 1 || CAL_CYCLES < CONV_CYCLES) begin
    $error("sar_dev: unsupported parameter values");
  end

  localparam int TW = $clog2(CAL_CYCLES + 1);
  localparam int BW = $clog2(RES_BITS);
  localparam int PW = $clog2(SAR_CAL_CLOCKS + 2);
  localparam logic [TW-1:0] CONV_LAST = TW'(CONV_CYCLES - 1);
  localparam logic [TW-1:0] CAL_LAST  = TW'(CAL_CYCLES - 1);
  localparam logic [BW-1:0] BIT_LAST  = BW'(RES_BITS - 1);
  localparam logic [PW-1:0] PULSE_CMD = PW'(SAR_CAL_CLOCKS);
  // One past the command count: any more pulses cannot be a command.
  localparam logic [PW-1:0] PULSE_SAT = PW'(SAR_CAL_CLOCKS + 1);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] pin_meta;  // First stage, read only by the second.
  logic [1:0] pin_sync;  // Second stage: {sclk, start line}.
  logic [1:0] pin_prev;  // Delayed copy for edge detection.

  // Two flops per pin before any logic looks at it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
      pin_prev <= 2'h0;
    end else begin
      pin_meta <= {link.sclk, link.convert_select_line};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic sel_lvl;    // Synchronised start line level.
  logic sel_rise;   // Start line rising edge, one cycle.
  logic sclk_rise;  // Serial clock rising edge, one cycle.
  logic sclk_fall;  // Serial clock falling edge, one cycle.

  assign sel_lvl   = pin_sync[0];
  assign sel_rise  = pin_sync[0] & ~pin_prev[0];
  assign sclk_rise = pin_sync[1] & ~pin_prev[1];
  assign sclk_fall = ~pin_sync[1] & pin_prev[1];

  // ---------------------------------------------------------------------
  // Saturation of the input level
  // ---------------------------------------------------------------------
  // Clamp the wider level into the result range.
  function automatic logic [RES_BITS-1:0] clamp_code(
    input logic signed [RES_BITS:0] lvl
  );
    logic [RES_BITS-1:0] res;
    res = lvl[RES_BITS-1:0];
    // Sign and next bit disagree only when out of range.
    if (lvl[RES_BITS] != lvl[RES_BITS-1]) begin
      res = {lvl[RES_BITS], {(RES_BITS - 1){~lvl[RES_BITS]}}};
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------
  // Main state
  // ---------------------------------------------------------------------
  sar_dev_state_t      state,      next_state;      // Phase.
  logic [TW-1:0]       timer,      next_timer;      // Phase timer.
  logic [PW-1:0]       pulses,     next_pulses;     // Pulses this frame.
  logic [BW-1:0]       bit_cnt,    next_bit_cnt;    // Falls this readout.
  logic [RES_BITS-1:0] sample,     next_sample;     // Held sample.
  logic [RES_BITS-1:0] shifter,    next_shifter;    // Output shifter.
  logic                ready,      next_ready;      // Result unread.
  logic                rd_en,      next_rd_en;      // Readout driving.
  logic                valid,      next_valid;      // Result pulse.
  logic [RES_BITS-1:0] code,       next_code;       // Last result.

  // Next-state logic for conversion, readout and calibration.
  always_comb begin
    next_state   = state;
    next_timer   = timer;
    next_pulses  = pulses;
    next_bit_cnt = bit_cnt;
    next_sample  = sample;
    next_shifter = shifter;
    next_ready   = ready;
    next_rd_en   = rd_en;
    next_valid   = 1'b0;
    next_code    = code;
    case (state)
      SAR_D_ACQ: begin
        // Count serial clocks in acquisition, saturating above 1024.
        if (sclk_rise && pulses != PULSE_SAT) begin
          next_pulses = pulses + PW'(1); // see RL8
        end
        if (rd_en) begin
          if (sel_lvl) begin
            // Start line back high ends the readout early.
            next_rd_en = 1'b0; // see RL6
            next_ready = 1'b0;
          end else if (sclk_fall) begin
            if (bit_cnt == BIT_LAST) begin
              // Last bit has been clocked out: let go of the line.
              next_rd_en = 1'b0; // see RL6
              next_ready = 1'b0;
            end else begin
              next_shifter = {shifter[RES_BITS-2:0], 1'b0}; // see RL4
              next_bit_cnt = bit_cnt + BW'(1);
            end
          end
        end else if (ready && !sel_lvl) begin
          // Shifter already holds the MSB, so it shows at once.
          next_rd_en   = 1'b1; // see RL3, RL14
          next_bit_cnt = '0;
        end
        if (sel_rise) begin
          next_rd_en  = 1'b0;
          next_ready  = 1'b0;
          next_timer  = '0;
          next_pulses = '0;
          if (pulses == PULSE_CMD) begin
            // Exactly the command count: calibrate instead.
            next_state   = SAR_D_CAL;    // see RL8
            next_shifter = '0;           // see RL9
          end else begin
            next_state  = SAR_D_CONV;    // see RL1
            next_sample = clamp_code(sample_level); // see RL12
          end
        end
      end
      SAR_D_CONV: begin
        // The start line is ignored until the timer expires.
        next_timer = timer + TW'(1); // see RL2
        if (timer == CONV_LAST) begin
          next_state   = SAR_D_ACQ;
          next_ready   = 1'b1;
          next_shifter = sample;
          next_code    = sample;
          next_valid   = 1'b1;
        end
      end
      SAR_D_CAL: begin
        // Line held low for the whole calibration time.
        next_timer = timer + TW'(1); // see RL11
        if (timer == CAL_LAST) begin
          next_state = SAR_D_ACQ;    // see RL9
          next_timer = '0;
        end
      end
      default: begin
        next_state = SAR_D_ACQ;
      end
    endcase
  end

  // Registers of the main state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= SAR_D_ACQ;
      timer   <= '0;
      pulses  <= '0;
      bit_cnt <= '0;
      sample  <= '0;
      shifter <= '0;
      ready   <= 1'b0;
      rd_en   <= 1'b0;
      valid   <= 1'b0;
      code    <= '0;
    end else begin
      state   <= next_state;
      timer   <= next_timer;
      pulses  <= next_pulses;
      bit_cnt <= next_bit_cnt;
      sample  <= next_sample;
      shifter <= next_shifter;
      ready   <= next_ready;
      rd_en   <= next_rd_en;
      valid   <= next_valid;
      code    <= next_code;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Shifter is cleared on entry to calibration, so its MSB reads low.
  assign link.serial_out_data = shifter[RES_BITS-1]; // see RL4, RL9
  assign link.serial_out_en   = rd_en | (state == SAR_D_CAL); // see RL9
  assign conv_busy    = (state == SAR_D_CONV);
  assign cal_busy     = (state == SAR_D_CAL);
  assign result_valid = valid;
  assign result_code  = code;

endmodule

// *** design/sar_host.sv ***
// Host end of the serial readout link: starts conversions, reads
// results and issues the calibration command.
// Assumes the line level from the link is asynchronous to clk.
`timescale 1ns/100ps
module sar_host import sar_pkg::*; #(
  parameter int RES_BITS  = SAR_RES_BITS,
  parameter int SCLK_HALF = SAR_SCLK_HALF,
  parameter int CNV_HIGH  = SAR_CNV_HIGH,
  parameter int CONV_WAIT = SAR_CONV_CYCLES + SAR_CONV_MARGIN
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                nrst,
  // Link to the converter.
  sar_link_if.host                 link,
  // Requests from local logic.
  input  wire logic                conv_req,
  input  wire logic                cal_req,
  // Status and results towards local logic.
  output logic                     idle,
  output logic                     data_valid,
  output logic [RES_BITS-1:0]      data_word,
  output logic                     cal_done
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  // Half periods below 8 leave no room for both synchronisers.
  if (RES_BITS < 2 || SCLK_HALF < 8 || CNV_HIGH < 4 || CONV_WAIT < 1)
  begin
    $error("sar_host: unsupported parameter values");
  end

  localparam int TW = $clog2(CONV_WAIT + CNV_HIGH + SCLK_HALF + 1);
  localparam int PW = $clog2(SAR_CAL_CLOCKS + 1);
  localparam logic [TW-1:0] HALF_LAST = TW'(SCLK_HALF - 1);
  localparam logic [TW-1:0] HIGH_LAST = TW'(CNV_HIGH - 1);
  localparam logic [TW-1:0] WAIT_LAST = TW'(CONV_WAIT - 1);
  localparam logic [PW-1:0] READ_LAST = PW'(RES_BITS - 1);
  localparam logic [PW-1:0] CMD_LAST  = PW'(SAR_CAL_CLOCKS - 1);

  // ---------------------------------------------------------------------
  // Line synchroniser
  // ---------------------------------------------------------------------
  logic line_meta;  // First stage, read only by the second.
  logic line_sync;  // Second stage, safe for logic.

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= link.serial_out_line;
      line_sync <= line_meta;
    end
  end

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  sar_host_state_t     state,  next_state;  // Phase.
  logic [TW-1:0]       timer,  next_timer;  // Phase and half-period timer.
  logic [PW-1:0]       pulses, next_pulses; // Pulses since start rose.
  logic                sel,    next_sel;    // Start line drive.
  logic                sck,    next_sck;    // Serial clock drive.
  logic                seen,   next_seen;   // Calibration low seen.
  logic [RES_BITS-1:0] word,   next_word;   // Captured bits.
  logic                dvalid, next_dvalid; // Result pulse.
  logic                cdone,  next_cdone;  // Calibration end pulse.

  // Next-state logic for triggering, reading and calibrating.
  always_comb begin
    next_state  = state;
    next_timer  = timer;
    next_pulses = pulses;
    next_sel    = sel;
    next_sck    = sck;
    next_seen   = seen;
    next_word   = word;
    next_dvalid = 1'b0;
    next_cdone  = 1'b0;
    case (state)
      SAR_H_IDLE: begin
        next_timer = '0;
        if (conv_req) begin
          // Rising start line: device samples and converts.
          next_sel    = 1'b1;
          next_pulses = '0;
          next_state  = SAR_H_TRIG;
        end else if (cal_req) begin
          // Pulses already sent since the last start count too.
          next_state = SAR_H_CLKS; // see RL8
        end
      end
      SAR_H_TRIG: begin
        next_timer = timer + TW'(1);
        if (timer == HIGH_LAST) begin
          next_timer = '0;
          next_state = SAR_H_WAIT;
        end
      end
      SAR_H_WAIT: begin
        // Lower the start line only once the conversion is done.
        next_timer = timer + TW'(1);
        if (timer == WAIT_LAST) begin
          next_sel   = 1'b0; // see RL3
          next_timer = '0;
          next_state = SAR_H_READ;
        end
      end
      SAR_H_READ, SAR_H_CLKS: begin
        next_timer = timer + TW'(1);
        if (timer == HALF_LAST) begin
          next_timer = '0;
          next_sck   = ~sck;
          if (!sck) begin
            // Capture on the rising edge: the bit has long settled.
            if (state == SAR_H_READ) begin
              next_word = {word[RES_BITS-2:0], line_sync}; // see RL5
            end
          end else begin
            next_pulses = pulses + PW'(1);
            if (state == SAR_H_READ && pulses == READ_LAST) begin
              next_dvalid = 1'b1;
              next_state  = SAR_H_IDLE;
            end else if (state == SAR_H_CLKS && pulses == CMD_LAST) begin
              // Command complete; start line rise closes the frame.
              next_sel    = 1'b1; // see RL8
              next_pulses = '0;
              next_state  = SAR_H_CEND;
            end
          end
        end
      end
      SAR_H_CEND: begin
        next_timer = timer + TW'(1);
        if (timer == HIGH_LAST) begin
          next_sel   = 1'b0;
          next_seen  = 1'b0;
          next_timer = '0;
          next_state = SAR_H_CWT;
        end
      end
      SAR_H_CWT: begin
        // Wait for the line to go low, then back high via pull-up.
        if (!line_sync) begin
          next_seen = 1'b1;
        end else if (seen) begin
          next_cdone = 1'b1;         // see RL10
          next_state = SAR_H_IDLE;   // see RL13
        end
      end
      default: begin
        next_state = SAR_H_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state  <= SAR_H_IDLE;
      timer  <= '0;
      pulses <= '0;
      sel    <= 1'b0;
      sck    <= 1'b0;
      seen   <= 1'b0;
      word   <= '0;
      dvalid <= 1'b0;
      cdone  <= 1'b0;
    end else begin
      state  <= next_state;
      timer  <= next_timer;
      pulses <= next_pulses;
      sel    <= next_sel;
      sck    <= next_sck;
      seen   <= next_seen;
      word   <= next_word;
      dvalid <= next_dvalid;
      cdone  <= next_cdone;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign link.convert_select_line = sel;
  assign link.sclk                = sck;
  assign link.serial_in_line      = 1'b1; // see RL7
  assign idle       = (state == SAR_H_IDLE);
  assign data_valid = dvalid;
  assign data_word  = word;
  assign cal_done   = cdone;

endmodule

// *** design/sar_link_if.sv ***
// Link between the converter end and the host end.
// Assumes a pull-up on the serial output line, resolved here.
`timescale 1ns/100ps
interface sar_link_if;

  // ---------------------------------------------------------------------
  // Link signals
  // ---------------------------------------------------------------------
  logic convert_select_line; // Start of conversion and chip select.
  logic sclk;                // Serial clock made by the host.
  logic serial_in_line;      // Serial input, held high by the host.
  logic serial_out_data;     // Value the device drives out.
  logic serial_out_en;       // High while the device drives the line.
  logic serial_out_line;     // Resolved line level with its pull-up.

  // When nobody drives, the pull-up makes the line read high.
  assign serial_out_line = serial_out_en ? serial_out_data : 1'b1;

  modport dev (
    input  convert_select_line,
    input  sclk,
    input  serial_in_line,
    output serial_out_data,
    output serial_out_en
  );

  modport host (
    output convert_select_line,
    output sclk,
    output serial_in_line,
    input  serial_out_line
  );

endinterface

// *** design/sar_pkg.sv ***
// Shared constants for the converter readout link and its two ends.
// Assumes both ends run from one 250 MHz system clock.
package sar_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  // System clock rate in hertz.
  localparam int SAR_CLK_HZ       = 250_000_000;
  // Self-calibration length in milliseconds, as quoted.
  localparam int SAR_CAL_TIME_MS  = 500;
  // Calibration length in clock cycles (longest time, rounded down).
  localparam int SAR_CAL_CYCLES   = SAR_CAL_TIME_MS * (SAR_CLK_HZ / 1000);
  // Conversion time in nanoseconds; a plain default for the model.
  localparam int SAR_CONV_TIME_NS = 700;
  // Conversion length in clock cycles (rounded up).
  localparam int SAR_CONV_CYCLES  =
    (SAR_CONV_TIME_NS * (SAR_CLK_HZ / 1_000_000) + 999) / 1000;

  // ---------------------------------------------------------------------
  // Link figures
  // ---------------------------------------------------------------------
  // Result width in bits.
  localparam int SAR_RES_BITS     = 16;
  // Serial clock pulses that form the calibration command.
  localparam int SAR_CAL_CLOCKS   = 1024;
  // Host serial clock half period in cycles (160 ns full period).
  localparam int SAR_SCLK_HALF    = 20;
  // Host keeps the start line high this long so the device sees it.
  localparam int SAR_CNV_HIGH     = 8;
  // Extra wait beyond the conversion time to cover synchroniser delay.
  localparam int SAR_CONV_MARGIN  = 8;

  // ---------------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------------
  // Device states: every step into or out of acquisition flips one bit.
  typedef enum logic [1:0] {
    SAR_D_ACQ  = 2'h0,
    SAR_D_CONV = 2'h1,
    SAR_D_CAL  = 2'h2
  } sar_dev_state_t;

  // Host states, Gray coded along the read path and from SAR_H_CLKS through SAR_H_CWT.
  typedef enum logic [2:0] {
    SAR_H_IDLE = 3'h0,
    SAR_H_TRIG = 3'h1,
    SAR_H_WAIT = 3'h3,
    SAR_H_READ = 3'h2,
    SAR_H_CLKS = 3'h6,
    SAR_H_CEND = 3'h7,
    SAR_H_CWT  = 3'h5
  } sar_host_state_t;

endpackage

// *** tb/sar_adc_serial_readout_test.sv ***
// Self-checking bench: host end and converter end joined by the link.
// Assumes the package and the link interface are compiled first.
`timescale 1ns/100ps
module sar_adc_serial_readout_test import sar_pkg::*;;
  localparam int CAL = 2000; // Short calibration keeps the run brief.
  logic clk, nrst, conv_req, cal_req, idle, data_valid, cal_done;
  logic conv_busy, cal_busy, result_valid, sclk_q;
  logic signed [16:0] sample_level;       // Level under conversion.
  logic [15:0] data_word, result_code, wire_sh; // Results seen.
  integer seed;                           // Fixed random seed.
  int rv_cnt;                             // Conversion-end pulses seen.
  int error_cnt, comparisons, i, last_wait;
  logic signed [16:0] corner [6] = '{17'sh07FFF, 17'sh08000,
    17'sh18000, 17'sh17FFF, 17'sh00000, 17'sh1FFFF};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  sar_link_if sar_link_if_inst ();
  sar_dev #(.CAL_CYCLES(CAL)) sar_dev_inst (.clk(clk), .nrst(nrst),
    .link(sar_link_if_inst), .sample_level(sample_level),
    .conv_busy(conv_busy), .cal_busy(cal_busy),
    .result_valid(result_valid), .result_code(result_code));
  sar_host sar_host_inst (.clk(clk), .nrst(nrst),
    .link(sar_link_if_inst), .conv_req(conv_req), .cal_req(cal_req),
    .idle(idle), .data_valid(data_valid), .data_word(data_word),
    .cal_done(cal_done));
  sar_link_asserts #(.RES_BITS(SAR_RES_BITS), .CAL_CYCLES(CAL))
    sar_link_asserts_inst (.clk(clk), .nrst(nrst),
    .convert_select_line(sar_link_if_inst.convert_select_line),
    .sclk(sar_link_if_inst.sclk),
    .serial_in_line(sar_link_if_inst.serial_in_line),
    .serial_out_data(sar_link_if_inst.serial_out_data),
    .serial_out_en(sar_link_if_inst.serial_out_en),
    .serial_out_line(sar_link_if_inst.serial_out_line));

  // Our own copy of the wire: line taken at each serial clock rise.
  always @(posedge clk) begin
    sclk_q <= sar_link_if_inst.sclk;
    if (result_valid) rv_cnt <= rv_cnt + 1;
    if (sar_link_if_inst.sclk && !sclk_q &&
        !sar_link_if_inst.convert_select_line) begin
      wire_sh <= {wire_sh[14:0], sar_link_if_inst.serial_out_line};
    end
  end

  // Expected code: two's complement, clipped at both full scales.
  function automatic logic [15:0] sat(input logic signed [16:0] v);
    if (v > 17'sh07FFF) return 16'h7FFF;
    if (v < 17'sh18000) return 16'h8000;
    return v[15:0];
  endfunction

  function automatic logic sig(input int w);
    case (w)
      0: return data_valid;
      1: return !sar_link_if_inst.serial_out_line;
      2: return cal_done;
      default: return !sar_link_if_inst.convert_select_line;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait; a wait that runs out counts as a mismatch.
  task automatic wait_on(input int w, input int lim);
    int n;
    n = 0;
    while (sig(w) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    last_wait = n;
    if (n == lim) chk(16'h0, 16'h1);
  endtask

  // One conversion and readout; the level moves after sampling.
  task automatic convert(input logic signed [16:0] lvl);
    logic [15:0] e;
    int          v0;
    e = sat(lvl);
    v0 = rv_cnt;
    @(posedge clk);
    sample_level <= lvl;
    conv_req <= 1'b1;
    @(posedge clk);
    conv_req <= 1'b0;
    repeat (30) @(posedge clk);
    chk({14'h0, conv_busy, idle}, 16'h2);
    sample_level <= ~lvl;
    wait_on(3, 400);
    repeat (6) @(posedge clk);
    #1;
    chk({15'h0, sar_link_if_inst.serial_out_line}, {15'h0, e[15]});
    wait_on(0, 1000);
    chk(data_word, e);
    chk(16'(rv_cnt - v0), 16'h1);
    chk(result_code, e);
    chk(wire_sh, e);
    repeat (8) @(posedge clk);
    chk({15'h0, sar_link_if_inst.serial_out_en}, 16'h0);
  endtask

  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    test_done();
  end

  initial begin
    {nrst, conv_req, cal_req, error_cnt, comparisons, rv_cnt} = '0;
    sample_level = 17'sh0;
    seed = 32'hd7772918;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 6; i++) convert(corner[i]);
    for (i = 0; i < 8; i++) convert(17'($random(seed)));
    @(posedge clk);
    cal_req <= 1'b1;
    @(posedge clk);
    cal_req <= 1'b0;
    wait_on(1, 50000);
    chk({15'h0, cal_busy}, 16'h1);
    wait_on(2, CAL + 100);
    chk({15'h0, last_wait > CAL - 10 && last_wait < CAL + 10}, 16'h1);
    chk({15'h0, sar_link_if_inst.serial_out_line}, 16'h1);
    convert(17'sh00123);
    // A reset in mid-readout must let go of the line at once.
    @(posedge clk);
    conv_req <= 1'b1;
    @(posedge clk);
    conv_req <= 1'b0;
    repeat (250) @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0, sar_link_if_inst.serial_out_en}, 16'h0);
    nrst <= 1'b1;
    convert(17'sh1FFFF);
    test_done();
  end
endmodule

// *** tb/sar_link_asserts.sv ***
// Checker for the signals of the converter readout link.
// Assumes it sits beside the link and samples on the system clock.
`timescale 1ns/100ps
module sar_link_asserts #(
  parameter int RES_BITS   = 16,
  parameter int CAL_CYCLES = 2000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Link signals, watched only.
  input wire logic convert_select_line,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic serial_out_data,
  input wire logic serial_out_en,
  input wire logic serial_out_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [31:0] lowc; // Cycles the line has stayed low so far.
  logic [10:0] fcnt; // Serial clock falls since the select line fell.

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  // The fall count saturates, since a calibration burst is long.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowc <= 32'h0;
      fcnt <= 11'h0;
    end else begin
      lowc <= serial_out_line ? 32'h0 : lowc + 32'h1;
      if (convert_select_line) fcnt <= 11'h0;
      else if ($fell(sclk) && fcnt != 11'h7FF) fcnt <= fcnt + 11'h1;
    end
  end

  a_serial_in_high: assert property (serial_in_line)
    else $error("Serial input left its high level");
  a_sel_min_high: assert property (
    $rose(convert_select_line) |-> convert_select_line[*8])
    else $error("Start pulse too short");
  a_sclk_low_start: assert property (
    $rose(convert_select_line) |-> !sclk)
    else $error("Serial clock high at conversion start");
  a_sclk_half_min: assert property ($rose(sclk) |-> sclk[*8])
    else $error("Serial clock high phase too short");
  a_bit_on_fall: assert property (
    serial_out_en && $past(serial_out_en) && $changed(serial_out_data)
      |-> !sclk)
    else $error("Output bit changed while serial clock high");
  a_last_bit_release: assert property (
    $rose(fcnt == RES_BITS) |-> ##[0:6] !serial_out_en)
    else $error("Output not released after the last bit");
  a_msb_prompt: assert property (
    $fell(convert_select_line) |-> ##[0:6] serial_out_en)
    else $error("Output not enabled after select fell");
  a_cal_length: assert property (
    serial_out_line && lowc > 1000 |->
      lowc >= CAL_CYCLES - 4 && lowc <= CAL_CYCLES + 4)
    else $error("Calibration low time off");
  a_cal_bound: assert property (lowc <= CAL_CYCLES + 4)
    else $error("Line held low too long");

  // Main scenarios: readout, last bit, calibration.
  c_readout: cover property ($fell(convert_select_line));
  c_last_bit: cover property ($rose(fcnt == RES_BITS));
  c_cal: cover property (serial_out_line && lowc > 1000);
endmodule
